// >>> common/cam_filter_map.vh
// register map, field positions and command codes of the address filter
`ifndef CAM_FILTER_MAP_VH
`define CAM_FILTER_MAP_VH

// ==========================================================
// register byte addresses
`define RA_COMP_LO 8'h00
`define RA_COMP_HI 8'h04
`define RA_MASK_LO 8'h08
`define RA_MASK_HI 8'h0c
`define RA_PERS    8'h10
`define RA_CMD     8'h14
`define RA_STATUS  8'h18
`define RA_RB_D_LO 8'h1c
`define RA_RB_D_HI 8'h20
`define RA_RB_M_LO 8'h24
`define RA_RB_M_HI 8'h28
`define RA_RB_PERS 8'h2c

// ==========================================================
// personality flag positions
`define PERS_W     6
`define PB_SRC_M   0
`define PB_SRC_X   1
`define PB_DST_M   2
`define PB_DST_X   3
`define PB_VALID   4
`define PB_SKIP    5

// ==========================================================
// status bit positions
`define SB_DONE    0
`define SB_ERR     1
`define SB_HIT     2
`define SB_MANY    3
`define SB_BUSY    4
`define SB_CUR_VLD 5
`define SB_IDX_LO  8

// ==========================================================
// command codes, in bits 2..0 of the command register
`define OP_W       3
`define OP_NONE    3'h0
`define OP_WRITE   3'h1
`define OP_FIND    3'h2
`define OP_READ    3'h3
`define OP_SKIP    3'h4
`define OP_INVAL   3'h5
`define OP_CLRSKIP 3'h6

// ==========================================================
// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> core/cam_entry_match.v
// one filter entry: masked comparator and personality qualification
`timescale 1ns/100ps
`default_nettype none
`include "cam_filter_map.vh"

module cam_entry_match #(
  parameter DATA_W = 48
) (
  // stored entry
  input  wire [DATA_W-1:0]  i_data,
  input  wire [DATA_W-1:0]  i_mask,
  input  wire [`PERS_W-1:0] i_pers,
  // shared comparand
  input  wire [DATA_W-1:0]  i_comp,
  // results
  output wire               o_hit,
  output wire               o_free
);

  wire raw;
  wire seen;

  // ==========================================================
  // comparator
  // R18: clear mask bit matches
  assign raw = &(~i_mask | ~(i_data ^ i_comp));

  // ==========================================================
  // qualification
  // R19: personality gates match
  assign seen = i_pers[`PB_SRC_M] | i_pers[`PB_DST_M];
  // R4: invalid never compares
  // R11: skipped entries excluded
  assign o_hit = raw & seen & i_pers[`PB_VALID] & ~i_pers[`PB_SKIP];
  // R5: invalid entry is free
  assign o_free = ~i_pers[`PB_VALID];

endmodule
`default_nettype wire

// >>> core/cam_prio_enc.v
// lowest-index priority encoder with any and more-than-one flags
`timescale 1ns/100ps
`default_nettype none

module cam_prio_enc #(
  parameter N     = 32,
  parameter IDX_W = 5
) (
  // request vector
  input  wire [N-1:0]     i_vec,
  // encoded result
  output reg  [IDX_W-1:0] o_idx,
  output wire             o_any,
  output wire             o_multi
);

  integer k;

  assign o_any   = |i_vec;
  // clearing the lowest set bit leaves something only if two or more are set
  assign o_multi = |(i_vec & (i_vec - {{(N-1){1'b0}}, 1'b1}));

  // R20: lowest index wins
  always @* begin
    o_idx = {IDX_W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (i_vec[k]) begin
        o_idx = k[IDX_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/cam_address_filter_mgmt.v
// address filter management: register port, command engine, entry store
`timescale 1ns/100ps
`default_nettype none
`include "cam_filter_map.vh"

// Notes on behaviour
// R1: comparand register holds its value until software writes it again.
// R2: mask register holds its value until software overwrites it.
// R3: personality register holds its flags until software overwrites it.
// R4: an entry with valid clear never takes part in a comparison.
// R5: write-entry stores into the lowest entry whose valid flag is clear.
// R6: software loads comparand, mask, personality, then issues write-entry.
// R7: done is set when a command completes; software then checks error.
// R8: write-entry never newly raises error while error is already set.
// R9: find compares the comparand without applying the host mask.
// R10: find sets hit on any unskipped match, many-hits on two or more.
// R11: entries with skip set are left out of find results.
// R12: invalidate removes the current matching entry from comparisons.
// R13: software alternates invalidate and find until hit is clear.
// R14: read-entry returns current entry's data, mask, flags to readback.
// R15: skip sets the skip flag of the current matching entry.
// R16: clear-all-skip clears the skip flag in every entry.
// R17: thirty-two 48-bit comparators check entries against the comparand.
// R18: clear mask bit matches; set bit needs equal data; bits are ANDed.
// R19: raw match is qualified by personality flags before it counts.
// R20: several matches: the current entry is the lowest-numbered one.
module cam_address_filter_mgmt #(
  parameter DATA_W  = 48,
  parameter ENTRIES = 32,
  parameter IDX_W   = 5,
  parameter ADDR_W  = 8
) (
  // clock and reset
  input  wire              I_CLK,
  input  wire              I_NRST,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] I_AWADDR,
  input  wire              I_AWVALID,
  output wire              O_AWREADY,
  // axi4-lite write data
  input  wire [31:0]       I_WDATA,
  input  wire [3:0]        I_WSTRB,
  input  wire              I_WVALID,
  output wire              O_WREADY,
  // axi4-lite write response
  output reg  [1:0]        O_BRESP,
  output reg               O_BVALID,
  input  wire              I_BREADY,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] I_ARADDR,
  input  wire              I_ARVALID,
  output wire              O_ARREADY,
  // axi4-lite read data
  output reg  [31:0]       O_RDATA,
  output reg  [1:0]        O_RRESP,
  output reg               O_RVALID,
  input  wire              I_RREADY
);

  localparam HI_W = DATA_W - 32;
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  // ==========================================================
  // state
  reg [31:0]         comp_lo_reg;
  reg [HI_W-1:0]     comp_hi_reg;
  reg [31:0]         mask_lo_reg;
  reg [HI_W-1:0]     mask_hi_reg;
  reg [`PERS_W-1:0]  pers_reg;
  reg [DATA_W-1:0]   rb_data_reg;
  reg [DATA_W-1:0]   rb_mask_reg;
  reg [`PERS_W-1:0]  rb_pers_reg;
  reg                state_reg;
  reg [`OP_W-1:0]    op_reg;
  reg                done_reg;
  reg                err_reg;
  reg                hit_reg;
  reg                many_reg;
  reg                cur_vld_reg;
  reg [IDX_W-1:0]    cur_idx_reg;
  reg                aw_held_reg;
  reg [ADDR_W-1:0]   awaddr_reg;
  reg                w_held_reg;
  reg [31:0]         wdata_reg;
  reg [3:0]          wstrb_reg;
  reg [DATA_W-1:0]   ent_data [0:ENTRIES-1];
  reg [DATA_W-1:0]   ent_mask [0:ENTRIES-1];
  reg [`PERS_W-1:0]  ent_pers [0:ENTRIES-1];

  wire [DATA_W-1:0]  comp;
  wire [DATA_W-1:0]  mask;
  wire [ENTRIES-1:0] hit_vec;
  wire [ENTRIES-1:0] free_vec;
  wire [IDX_W-1:0]   hit_idx;
  wire               hit_any;
  wire               hit_multi;
  wire [IDX_W-1:0]   free_idx;
  wire               free_any;
  wire               do_wr;
  wire [32:0]        wr_cur;
  wire [31:0]        wr_val;
  wire [32:0]        rd_cur;
  wire               cmd_wr;
  wire               exec;
  integer            k;

  assign comp = {comp_hi_reg, comp_lo_reg};
  assign mask = {mask_hi_reg, mask_lo_reg};

  // ==========================================================
  // comparator array
  // R17: one comparator per entry
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
      cam_entry_match #(
        .DATA_W (DATA_W)
      ) u_match (
        .i_data (ent_data[g]),
        .i_mask (ent_mask[g]),
        .i_pers (ent_pers[g]),
        .i_comp (comp),
        .o_hit  (hit_vec[g]),
        .o_free (free_vec[g])
      );
    end
  endgenerate

  // R20: lowest hit is current
  cam_prio_enc #(
    .N     (ENTRIES),
    .IDX_W (IDX_W)
  ) u_hit_enc (
    .i_vec   (hit_vec),
    .o_idx   (hit_idx),
    .o_any   (hit_any),
    .o_multi (hit_multi)
  );

  // R5: lowest free entry
  cam_prio_enc #(
    .N     (ENTRIES),
    .IDX_W (IDX_W)
  ) u_free_enc (
    .i_vec   (free_vec),
    .o_idx   (free_idx),
    .o_any   (free_any),
    .o_multi ()
  );

  // ==========================================================
  // register read view, bit 32 flags a mapped address
  function [32:0] reg_rd;
    input [ADDR_W-1:0] a;
    begin
      reg_rd = {1'b1, 32'h0000_0000};
      case (a)
        `RA_COMP_LO: reg_rd[31:0] = comp_lo_reg;
        `RA_COMP_HI: reg_rd[HI_W-1:0] = comp_hi_reg;
        `RA_MASK_LO: reg_rd[31:0] = mask_lo_reg;
        `RA_MASK_HI: reg_rd[HI_W-1:0] = mask_hi_reg;
        `RA_PERS:    reg_rd[`PERS_W-1:0] = pers_reg;
        `RA_CMD:     reg_rd[`OP_W-1:0] = op_reg;
        `RA_STATUS: begin
          reg_rd[`SB_DONE]    = done_reg;
          reg_rd[`SB_ERR]     = err_reg;
          reg_rd[`SB_HIT]     = hit_reg;
          reg_rd[`SB_MANY]    = many_reg;
          reg_rd[`SB_BUSY]    = state_reg;
          reg_rd[`SB_CUR_VLD] = cur_vld_reg;
          reg_rd[`SB_IDX_LO+IDX_W-1:`SB_IDX_LO] = cur_idx_reg;
        end
        `RA_RB_D_LO: reg_rd[31:0] = rb_data_reg[31:0];
        `RA_RB_D_HI: reg_rd[HI_W-1:0] = rb_data_reg[DATA_W-1:32];
        `RA_RB_M_LO: reg_rd[31:0] = rb_mask_reg[31:0];
        `RA_RB_M_HI: reg_rd[HI_W-1:0] = rb_mask_reg[DATA_W-1:32];
        `RA_RB_PERS: reg_rd[`PERS_W-1:0] = rb_pers_reg;
        default:     reg_rd = 33'h0_0000_0000;
      endcase
    end
  endfunction

  // byte-lane merge of write data over the old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  s;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1) begin
        merge[b*8 +: 8] = s[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // axi4-lite write channel
  // address and data are held separately so either may come first
  assign O_AWREADY = ~aw_held_reg;
  assign O_WREADY  = ~w_held_reg;
  assign do_wr     = aw_held_reg & w_held_reg & ~O_BVALID;
  assign wr_cur    = reg_rd(awaddr_reg);
  assign wr_val    = merge(wr_cur[31:0], wdata_reg, wstrb_reg);
  assign cmd_wr    = do_wr & (awaddr_reg == `RA_CMD) & wstrb_reg[0];
  assign exec      = (state_reg == ST_EXEC);

  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= {ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      O_BVALID    <= 1'b0;
      O_BRESP     <= `RESP_OKAY;
    end else begin
      if (I_AWVALID && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= I_AWADDR;
      end
      if (I_WVALID && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= I_WDATA;
        wstrb_reg  <= I_WSTRB;
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        O_BVALID    <= 1'b1;
        O_BRESP     <= wr_cur[32] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  assign O_ARREADY = ~O_RVALID;
  assign rd_cur    = reg_rd(I_ARADDR);

  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= `RESP_OKAY;
    end else if (I_ARVALID && !O_RVALID) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd_cur[31:0];
      O_RRESP  <= rd_cur[32] ? `RESP_OKAY : `RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // holding registers, changed only by software writes
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      comp_lo_reg <= 32'h0000_0000;
      comp_hi_reg <= {HI_W{1'b0}};
      mask_lo_reg <= 32'h0000_0000;
      mask_hi_reg <= {HI_W{1'b0}};
      pers_reg    <= {`PERS_W{1'b0}};
    end else if (do_wr) begin
      case (awaddr_reg)
        // R1: comparand by write only
        `RA_COMP_LO: comp_lo_reg <= wr_val;
        `RA_COMP_HI: comp_hi_reg <= wr_val[HI_W-1:0];
        // R2: mask by write only
        `RA_MASK_LO: mask_lo_reg <= wr_val;
        `RA_MASK_HI: mask_hi_reg <= wr_val[HI_W-1:0];
        // R3: flags by write only
        `RA_PERS:    pers_reg <= wr_val[`PERS_W-1:0];
        default:     pers_reg <= pers_reg;
      endcase
    end
  end

  // ==========================================================
  // command engine: a command runs in the cycle after it is written
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg   <= ST_IDLE;
      op_reg      <= `OP_NONE;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
      hit_reg     <= 1'b0;
      many_reg    <= 1'b0;
      cur_vld_reg <= 1'b0;
      cur_idx_reg <= {IDX_W{1'b0}};
    end else begin
      // error is write-one-to-clear; a raise below overrides it
      if (do_wr && awaddr_reg == `RA_STATUS && wstrb_reg[0] &&
          wdata_reg[`SB_ERR]) begin
        err_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          // commands written while busy are dropped
          if (cmd_wr) begin
            op_reg    <= wdata_reg[`OP_W-1:0];
            done_reg  <= 1'b0;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // R7: done on completion
          done_reg  <= 1'b1;
          state_reg <= ST_IDLE;
          case (op_reg)
            `OP_WRITE: begin
              // R8: no raise when already set
              if (!free_any && !err_reg) begin
                err_reg <= 1'b1;
              end
            end
            `OP_FIND: begin
              // R9: host mask not applied
              // R10: hit and many-hits
              hit_reg     <= hit_any;
              many_reg    <= hit_any & hit_multi;
              cur_vld_reg <= hit_any;
              cur_idx_reg <= hit_idx;
            end
            `OP_READ, `OP_SKIP: begin
              if (!cur_vld_reg) begin
                err_reg <= 1'b1;
              end
            end
            `OP_INVAL: begin
              // R12: current entry consumed
              cur_vld_reg <= 1'b0;
              if (!cur_vld_reg) begin
                err_reg <= 1'b1;
              end
            end
            `OP_CLRSKIP: begin
              cur_vld_reg <= cur_vld_reg;
            end
            default: begin
              err_reg <= 1'b1;
            end
          endcase
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // entry flags, reset to invalid
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (k = 0; k < ENTRIES; k = k + 1) begin
        ent_pers[k] <= {`PERS_W{1'b0}};
      end
    end else if (exec) begin
      case (op_reg)
        `OP_WRITE: begin
          // R5: lowest free entry taken
          if (free_any) begin
            ent_pers[free_idx] <= pers_reg;
          end
        end
        `OP_SKIP: begin
          // R15: mark current as skipped
          if (cur_vld_reg) begin
            ent_pers[cur_idx_reg][`PB_SKIP] <= 1'b1;
          end
        end
        `OP_INVAL: begin
          // R12: clear valid of current
          if (cur_vld_reg) begin
            ent_pers[cur_idx_reg][`PB_VALID] <= 1'b0;
          end
        end
        `OP_CLRSKIP: begin
          // R16: clear every skip flag
          for (k = 0; k < ENTRIES; k = k + 1) begin
            ent_pers[k][`PB_SKIP] <= 1'b0;
          end
        end
        default: begin
          ent_pers[0] <= ent_pers[0];
        end
      endcase
    end
  end

  // ==========================================================
  // entry data and mask: plain storage, no reset needed
  // R5: contents into free entry
  always @(posedge I_CLK) begin
    if (exec && op_reg == `OP_WRITE && free_any) begin
      ent_data[free_idx] <= comp;
      ent_mask[free_idx] <= mask;
    end
  end

  // ==========================================================
  // readback of the current entry
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rb_data_reg <= {DATA_W{1'b0}};
      rb_mask_reg <= {DATA_W{1'b0}};
      rb_pers_reg <= {`PERS_W{1'b0}};
    end else if (exec && op_reg == `OP_READ && cur_vld_reg) begin
      // R14: current entry to host
      rb_data_reg <= ent_data[cur_idx_reg];
      rb_mask_reg <= ent_mask[cur_idx_reg];
      rb_pers_reg <= ent_pers[cur_idx_reg];
    end
  end

endmodule
`default_nettype wire

// >>> tb/cam_filter_assertions.sv
// register port checker of the address filter, with its bind
`timescale 1ns/100ps
`default_nettype none
`include "cam_filter_map.vh"
// ============================================================
// checker
module cam_filter_chk #(
  parameter ADDR_W = 8
) (
  input wire logic              I_CLK, I_NRST,
  input wire logic [ADDR_W-1:0] I_AWADDR, I_ARADDR,
  input wire logic [31:0]       I_WDATA, O_RDATA,
  input wire logic [3:0]        I_WSTRB,
  input wire logic [1:0]        O_BRESP, O_RRESP,
  input wire logic              I_AWVALID, O_AWREADY, I_WVALID, O_WREADY,
  input wire logic              O_BVALID, I_BREADY, I_ARVALID, O_ARREADY,
  input wire logic              O_RVALID, I_RREADY
);
  wire aw_t   = I_AWVALID && O_AWREADY;
  wire w_t    = I_WVALID && O_WREADY;
  wire ar_t   = I_ARVALID && O_ARREADY;
  // no write in flight, so a finished command has settled
  wire idle_w = O_AWREADY && O_WREADY && !O_BVALID;
  wire st_ar  = ar_t && I_ARADDR == `RA_STATUS;
  reg  cmd_seen;
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST)
      cmd_seen <= 1'b0;
    else if (aw_t && I_AWADDR == `RA_CMD)
      cmd_seen <= 1'b1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_aw_held: assert property (aw_t |=> !O_AWREADY)
    else $error("write address taken while one is held");
  a_b_latency: assert property (aw_t && w_t && !O_BVALID |-> ##2 O_BVALID)
    else $error("write response late");
  a_b_stands: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_b_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");
  a_r_latency: assert property (ar_t |=> O_RVALID)
    else $error("read data late");
  a_r_stands: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
    else $error("read data dropped");
  a_ar_blocked: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while data pending");
  a_unmapped_read: assert property (ar_t && I_ARADDR > 8'h2c |=>
    O_RRESP == `RESP_SLVERR && O_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_unmapped_write: assert property (aw_t && w_t && I_AWADDR > 8'h2c |->
    ##2 O_BRESP == `RESP_SLVERR)
    else $error("unmapped write not refused");
  a_done_after_cmd: assert property (st_ar && cmd_seen && idle_w |=>
    O_RDATA[`SB_DONE] && !O_RDATA[`SB_BUSY])
    else $error("command not done by status read");
  a_many_needs_hit: assert property (st_ar |=>
    !(O_RDATA[`SB_MANY] && !O_RDATA[`SB_HIT]))
    else $error("many hits without hit");
  c_many: cover property (O_RVALID && O_RDATA[`SB_MANY]);
  c_slverr: cover property (O_RVALID && O_RRESP == `RESP_SLVERR);
  c_err: cover property (O_RVALID && O_RDATA[`SB_ERR]);
endmodule

bind cam_address_filter_mgmt cam_filter_chk #(.ADDR_W(ADDR_W)) chk_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_AWADDR(I_AWADDR),
  .I_ARADDR(I_ARADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
  .I_WSTRB(I_WSTRB), .O_BRESP(O_BRESP), .O_RRESP(O_RRESP),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY)
);
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the address filter register port
`timescale 1ns/100ps
`default_nettype none
`include "cam_filter_map.vh"
module tb;
  // ============================================================
  // clock and design
  logic              I_CLK = 1'b0;
  logic              I_NRST = 1'b0;
  logic [7:0]        I_AWADDR = 8'h00;
  logic [7:0]        I_ARADDR = 8'h00;
  logic [31:0]       I_WDATA = 32'h0;
  logic [3:0]        I_WSTRB = 4'h0;
  logic              I_AWVALID = 1'b0;
  logic              I_WVALID = 1'b0;
  logic              I_BREADY = 1'b0;
  logic              I_ARVALID = 1'b0;
  logic              I_RREADY = 1'b0;
  wire logic         O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  wire logic [1:0]   O_BRESP, O_RRESP;
  wire logic [31:0]  O_RDATA;
  integer            fails = 0;
  integer            num_checks = 0;
  integer            i;
  logic [31:0]       st, rv;
  logic [1:0]        rs;
  logic [47:0]       d, m, f;
  localparam [47:0]  ONES = 48'hffff_ffff_ffff;
  always #25 I_CLK = ~I_CLK;
  cam_address_filter_mgmt dut_u (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_AWADDR(I_AWADDR),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY)
  );
  // ============================================================
  // reporting
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task tend(input string s);
    $display("test %s finished", s);
  endtask
  // ============================================================
  // bus tasks
  // each request waits one edge first, so no signal is set twice a step
  task wr(input [7:0] a, input [31:0] v);
    integer n;
    begin
      @(posedge I_CLK);
      I_AWADDR <= a;
      I_WDATA <= v;
      I_WSTRB <= 4'hf;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      n = 0;
      while (n < 40) begin
        @(posedge I_CLK);
        n = n + 1;
        if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
        if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
        if (O_BVALID === 1'b1) n = 99;
      end
      I_BREADY <= 1'b0;
      rs = O_BRESP;
      if (n != 99) chk(32'h0, 32'h1);
    end
  endtask
  task rd(input [7:0] a);
    integer n;
    begin
      @(posedge I_CLK);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      n = 0;
      while (n < 40) begin
        @(posedge I_CLK);
        n = n + 1;
        if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
        if (O_RVALID === 1'b1) n = 99;
      end
      I_RREADY <= 1'b0;
      rv = O_RDATA;
      rs = O_RRESP;
      if (n != 99) chk(32'h0, 32'h1);
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(rv, e);
    end
  endtask
  task op(input [2:0] c);
    begin
      wr(`RA_CMD, {29'h0, c});
      rd(`RA_STATUS);
      st = rv;
    end
  endtask
  task put(input [47:0] dv, input [47:0] mv, input [5:0] p);
    begin
      wr(`RA_COMP_LO, dv[31:0]);
      wr(`RA_COMP_HI, {16'h0, dv[47:32]});
      wr(`RA_MASK_LO, mv[31:0]);
      wr(`RA_MASK_HI, {16'h0, mv[47:32]});
      wr(`RA_PERS, {26'h0, p});
      op(`OP_WRITE);
    end
  endtask
  // ============================================================
  // expectation functions
  function [31:0] fexp(input h, input mny, input [4:0] ix);
    fexp = {19'h0, ix, 2'h0, h, 1'b0, mny, h, 2'h1};
  endfunction
  function hitf(input [47:0] dv, input [47:0] mv, input [47:0] cv);
    hitf = &(~mv | ~(dv ^ cv));
  endfunction
  // index and current-valid mean nothing without a hit
  task fchk(input [47:0] c, input h, input mny, input [4:0] ix);
    logic [31:0] k;
    begin
      wr(`RA_COMP_LO, c[31:0]);
      wr(`RA_COMP_HI, {16'h0, c[47:32]});
      op(`OP_FIND);
      k = h ? 32'h1f3f : 32'h000f;
      chk(st & k, fexp(h, mny, ix) & k);
    end
  endtask
  // ============================================================
  // tests
  initial begin
    rv = $urandom(82535);
    repeat (4) @(posedge I_CLK);
    I_NRST <= 1'b1;
    rdchk(`RA_STATUS, 32'h0);
    rdchk(`RA_PERS, 32'h0);
    tend("reset");
    d = 48'({$urandom, $urandom});
    put(d, ONES, 6'h01);
    fchk(d, 0, 0, 0); // invalid ignored
    put(d, ONES, 6'h10);
    chk(st & 32'h3, 32'h1); // free slot reused
    fchk(d, 0, 0, 0); // flags qualify
    tend("qualify");
    d = 48'({$urandom, $urandom});
    put(d, ONES, 6'h14);
    chk(st & 32'h3, 32'h1); // done no error
    rdchk(`RA_COMP_LO, d[31:0]); // comparand kept
    rdchk(`RA_COMP_HI, {16'h0, d[47:32]}); // comparand kept
    rdchk(`RA_MASK_HI, 32'h0000ffff); // mask kept
    rdchk(`RA_PERS, 32'h14); // flags kept
    put(d, ONES, 6'h11);
    fchk(d, 1, 1, 1); // lowest of two
    op(`OP_READ);
    rdchk(`RA_RB_D_LO, d[31:0]); // data back
    rdchk(`RA_RB_D_HI, {16'h0, d[47:32]}); // data back
    rdchk(`RA_RB_M_LO, ONES[31:0]); // mask back
    rdchk(`RA_RB_PERS, 32'h14); // flags back
    op(`OP_SKIP);
    fchk(d, 1, 0, 2); // skipped left out
    op(`OP_INVAL);
    fchk(d, 0, 0, 0); // entry removed
    op(`OP_CLRSKIP);
    fchk(d, 1, 0, 1); // skip cleared
    op(`OP_INVAL);
    fchk(d, 0, 0, 0); // all removed
    tend("find_skip_invalidate");
    for (i = 0; i < 8; i = i + 1) begin
      d = 48'({$urandom, $urandom});
      m = (i == 0) ? 48'h0 : 48'({$urandom, $urandom});
      f = 48'h1 << ($urandom % 48);
      put(d, m, 6'h11);
      wr(`RA_MASK_LO, 32'h0);
      wr(`RA_MASK_HI, 32'h0);
      fchk(d ^ f, hitf(d, m, d ^ f), 0, 1); // per-bit mask
      fchk(d, 1, 0, 1); // exact compare
      op(`OP_INVAL);
    end
    tend("random_masks");
    for (i = 1; i < 32; i = i + 1) begin
      put(48'(i), ONES, 6'h11);
      chk(st & 32'h3, 32'h1); // free slot taken
    end
    put(48'h64, ONES, 6'h11);
    chk(st & 32'h3, 32'h3); // full table error
    put(48'h64, ONES, 6'h11);
    chk(st & 32'h3, 32'h3); // error stays set
    wr(`RA_STATUS, 32'h2);
    rd(`RA_STATUS);
    chk(rv & 32'h3, 32'h1); // error cleared
    fchk(48'h7, 1, 0, 7); // single index
    op(`OP_INVAL);
    put(48'h64, ONES, 6'h11);
    fchk(48'h64, 1, 0, 7); // freed slot reused
    tend("fill");
    wr(8'h40, 32'h5a);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    rd(8'h40);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    chk(rv, 32'h0);
    op(3'h7);
    chk(st & 32'h3, 32'h3);
    tend("refusals");
    complete_run;
  end
  // the run needs under two thousand cycles; this limit of 20000 cycles leaves ample margin
  initial begin
    #1000000;
    fails = fails + 1;
    complete_run;
  end
endmodule
`default_nettype wire
